/* hdl/psram_host_regs.svh */
// timing counts and fixed codes for the pseudo-static ram host controller
// assumes a single 40 mhz clock; every count is derived here from its time
`ifndef PSRAM_HOST_REGS_SVH
`define PSRAM_HOST_REGS_SVH

// ------------------------------------------------------------------
// clock and power-up timing
// ------------------------------------------------------------------
`define CLK_MHZ                           40
`define PWR_LOW_US                        50
`define SELECT_HIGH_TO_STANDBY_RELEASE_NS 0
`define RELEASE_TO_FIRST_SELECT_HOLD_US   200
`define PWR_LOW_CYC      (`PWR_LOW_US * `CLK_MHZ)
`define HOLD_CYC         (`RELEASE_TO_FIRST_SELECT_HOLD_US * `CLK_MHZ)

// ------------------------------------------------------------------
// access timing, least times rounded up
// ------------------------------------------------------------------
`define ACC_NS           90
`define PAGE_NS          40
`define ACC_CYC          ((`ACC_NS * `CLK_MHZ + 999) / 1000)
`define PAGE_CYC         ((`PAGE_NS * `CLK_MHZ + 999) / 1000)

// ------------------------------------------------------------------
// mode register entry
// ------------------------------------------------------------------
`define TOP_ADDR         21'h1fffff
`define MR_FIRST_DATA    16'h0000
`define MR_BASE_DATA     16'h0004
`define PAGE_LSB         3
`define DENSITY_NONE     2'h3

`endif

/* hdl/psram_host_pkg.sv */
// types of the pseudo-static ram host controller
// assumes the timing header is included by the modules that need counts
package psram_host_pkg;

  // ------------------------------------------------------------------
  // controller states
  // ------------------------------------------------------------------
  typedef enum logic [6:0] {
    S_PWR_LOW   = 7'h01,
    S_PWR_HOLD  = 7'h02,
    S_IDLE      = 7'h04,
    S_ACCESS    = 7'h08,
    S_PAGE_WAIT = 7'h10,
    S_RECOVER   = 7'h20,
    S_SLEEP     = 7'h40
  } state_type;

  typedef struct packed {
    state_type   state;
    logic        tmArmed;
    logic [20:0] addr;
    logic [15:0] dout;
    logic        dqOe;
    logic        csN;
    logic        oeN;
    logic        weN;
    logic        lbN;
    logic        hbN;
    logic        standby;
    logic        isWrite;
    logic        isPage;
    logic        rspValid;
    logic [15:0] rspData;
    logic        progActive;
    logic [1:0]  progIdx;
    logic [1:0]  progCode;
    logic [1:0]  density;
    logic        densityValid;
  } host_type;

  typedef struct packed {
    logic [13:0] left;
  } timer_type;

endpackage

/* hdl/psram_wait_if.sv */
// load and done handshake between the controller and its wait timer
// assumes both ends share the controller clock
`timescale 1ns/1ps
interface psram_wait_if;
  logic        load;
  logic [13:0] count;
  logic        done;

  modport ctrl  (output load, output count, input done);
  modport timer (input load, input count, output done);
endinterface

/* hdl/psram_wait_timer.sv */
// down counter: load n, done is high in the n-th cycle after the load
// assumes n is at least one; a load while running restarts the count
`timescale 1ns/1ps
module psram_wait_timer (
  input  wire logic     clk,
  input  wire logic     rst_n,
  psram_wait_if.timer   wt
);

  psram_host_pkg::timer_type r_ff;
  psram_host_pkg::timer_type nxt_r;

  always_comb begin
    nxt_r = r_ff;
    if (wt.load) begin
      nxt_r.left = wt.count;
    end else if (r_ff.left != 14'h0) begin
      nxt_r.left = r_ff.left - 14'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign wt.done = (r_ff.left == 14'h1);

endmodule

/* hdl/psram_host.sv */
// host controller for a 2m x 16 pseudo-static ram with standby pin
// assumes pin inputs are synchronous to clk and the device sits on the pins
`timescale 1ns/1ps
`include "psram_host_regs.svh"

module psram_host #(
  parameter logic [13:0] holdCycles = 14'(`HOLD_CYC)
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // user side
  input  wire logic        reqValid,
  output wire logic        reqReady,
  input  wire logic        reqWrite,
  input  wire logic [20:0] reqAddr,
  input  wire logic [15:0] reqData,
  input  wire logic [1:0]  reqByteEn,
  output wire logic        rspValid,
  output wire logic [15:0] rspData,
  input  wire logic        densityReq,
  input  wire logic [1:0]  densityCode,
  input  wire logic        sleepReq,
  input  wire logic        wakeReq,
  output wire logic        cmdReady,
  output wire logic        initDone,
  output wire logic        sleeping,
  output wire logic        densityValid,
  // device pins
  output wire logic [20:0] addrPin,
  output wire logic [15:0] dqOut,
  output wire logic        dqOe,
  input  wire logic [15:0] dqIn,
  output wire logic        csN,
  output wire logic        oeN,
  output wire logic        weN,
  output wire logic        low_byte_sel_n,
  output wire logic        high_byte_sel_n,
  output wire logic        standbyCtl
);

  // ------------------------------------------------------------------
  // state, timer and helpers
  // ------------------------------------------------------------------
  psram_host_pkg::host_type r_ff;
  psram_host_pkg::host_type nxt_r;
  psram_wait_if             wt ();

  psram_wait_timer u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .wt    (wt)
  );

  function automatic logic samePage(input logic [20:0] a, input logic [20:0] b);
    samePage = (a[20:`PAGE_LSB] == b[20:`PAGE_LSB]);
  endfunction

  // open one bus cycle; select stays low across a page
  function automatic psram_host_pkg::host_type startAccess(
    input psram_host_pkg::host_type s,
    input logic                     wr,
    input logic [20:0]              a,
    input logic [15:0]              d,
    input logic [1:0]               be,
    input logic                     page
  );
    psram_host_pkg::host_type t;
    t         = s;
    t.state   = psram_host_pkg::S_ACCESS;
    t.addr    = a;
    t.dout    = d;
    t.isWrite = wr;
    t.isPage  = page;
    // a page continuation starts while the previous answer pulse is still up
    t.rspValid = 1'b0;
    t.csN     = 1'b0;
    t.oeN     = wr;
    t.weN     = !wr;
    t.dqOe    = wr;
    t.lbN     = !be[0];
    t.hbN     = !be[1];
    startAccess = t;
  endfunction

  logic pageHit;
  assign pageHit = (r_ff.state == psram_host_pkg::S_PAGE_WAIT) && reqValid && !reqWrite
                   && samePage(reqAddr, r_ff.addr);

  assign reqReady = ((r_ff.state == psram_host_pkg::S_IDLE) && !densityReq && !sleepReq)
                    || pageHit;
  assign cmdReady = (r_ff.state == psram_host_pkg::S_IDLE) ||
                    (r_ff.state == psram_host_pkg::S_SLEEP);

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    logic [15:0] progData;
    progData    = `MR_BASE_DATA | {14'h0, r_ff.progCode};
    nxt_r       = r_ff;
    nxt_r.rspValid = 1'b0;
    wt.load     = 1'b0;
    wt.count    = 14'h1;
    unique case (r_ff.state)
      psram_host_pkg::S_PWR_LOW: begin
        nxt_r.standby = 1'b0;
        nxt_r.csN     = 1'b1;
        if (!r_ff.tmArmed) begin
          nxt_r.tmArmed = 1'b1;
          wt.load       = 1'b1;
          wt.count      = 14'(`PWR_LOW_CYC);
        end else if (wt.done) begin
          // select is already high, so the release separation is met
          nxt_r.standby = 1'b1;
          nxt_r.state   = psram_host_pkg::S_PWR_HOLD;
          wt.load       = 1'b1;
          wt.count      = holdCycles;
        end
      end
      psram_host_pkg::S_PWR_HOLD: begin
        if (wt.done) begin
          nxt_r.state = psram_host_pkg::S_IDLE;
        end
      end
      psram_host_pkg::S_IDLE: begin
        if (densityReq) begin
          nxt_r            = startAccess(r_ff, 1'b0, `TOP_ADDR, 16'h0, 2'h3, 1'b0);
          nxt_r.progActive = 1'b1;
          nxt_r.progIdx    = 2'h0;
          nxt_r.progCode   = densityCode;
        end else if (sleepReq && r_ff.densityValid) begin
          nxt_r.standby = 1'b0;
          nxt_r.state   = psram_host_pkg::S_SLEEP;
        end else if (reqValid && !sleepReq) begin
          // a refused sleep keeps ready low, so no request may slip in then
          nxt_r = startAccess(r_ff, reqWrite, reqAddr, reqData, reqByteEn, 1'b0);
        end
      end
      psram_host_pkg::S_ACCESS: begin
        if (wt.done) begin
          nxt_r.weN = 1'b1;
          if (!r_ff.isWrite && !r_ff.progActive) begin
            nxt_r.rspValid = 1'b1;
            nxt_r.rspData  = dqIn;
            nxt_r.state    = psram_host_pkg::S_PAGE_WAIT;
          end else begin
            nxt_r.state = psram_host_pkg::S_RECOVER;
          end
          if (r_ff.progActive) begin
            nxt_r.progIdx = r_ff.progIdx + 2'h1;
          end
        end
      end
      psram_host_pkg::S_PAGE_WAIT: begin
        // one cycle to continue the page; anything else closes it
        if (pageHit) begin
          nxt_r = startAccess(r_ff, 1'b0, reqAddr, 16'h0, reqByteEn, 1'b1);
        end else begin
          nxt_r.state = psram_host_pkg::S_RECOVER;
        end
      end
      psram_host_pkg::S_RECOVER: begin
        nxt_r.csN  = 1'b1;
        nxt_r.oeN  = 1'b1;
        nxt_r.weN  = 1'b1;
        nxt_r.dqOe = 1'b0;
        nxt_r.state = psram_host_pkg::S_IDLE;
        if (r_ff.progActive && r_ff.csN) begin
          if (r_ff.progIdx == 2'h0) begin
            nxt_r.progActive   = 1'b0;
            nxt_r.density      = r_ff.progCode;
            nxt_r.densityValid = 1'b1;
          end else begin
            nxt_r = startAccess(r_ff, r_ff.progIdx[1], `TOP_ADDR,
                                (r_ff.progIdx == 2'h2) ? `MR_FIRST_DATA : progData,
                                2'h3, 1'b0);
          end
        end else if (r_ff.progActive) begin
          nxt_r.state = psram_host_pkg::S_RECOVER;
        end
      end
      psram_host_pkg::S_SLEEP: begin
        if (wakeReq) begin
          if (r_ff.density == `DENSITY_NONE) begin
            nxt_r.state   = psram_host_pkg::S_PWR_LOW;
            nxt_r.tmArmed = 1'b0;
          end else begin
            nxt_r.standby = 1'b1;
            nxt_r.state   = psram_host_pkg::S_IDLE;
          end
        end
      end
    endcase
    if ((nxt_r.state == psram_host_pkg::S_ACCESS) &&
        (r_ff.state != psram_host_pkg::S_ACCESS)) begin
      wt.load  = 1'b1;
      wt.count = nxt_r.isPage ? 14'(`PAGE_CYC) : 14'(`ACC_CYC);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_ff         <= '0;
      r_ff.state   <= psram_host_pkg::S_PWR_LOW;
      r_ff.csN     <= 1'b1;
      r_ff.oeN     <= 1'b1;
      r_ff.weN     <= 1'b1;
      r_ff.lbN     <= 1'b1;
      r_ff.hbN     <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign addrPin         = r_ff.addr;
  assign dqOut           = r_ff.dout;
  assign dqOe            = r_ff.dqOe;
  assign csN             = r_ff.csN;
  assign oeN             = r_ff.oeN;
  assign weN             = r_ff.weN;
  assign low_byte_sel_n  = r_ff.lbN;
  assign high_byte_sel_n = r_ff.hbN;
  assign standbyCtl      = r_ff.standby;
  assign rspValid        = r_ff.rspValid;
  assign rspData         = r_ff.rspData;
  assign initDone        = !(r_ff.state inside {psram_host_pkg::S_PWR_LOW,
                                                psram_host_pkg::S_PWR_HOLD});
  assign sleeping        = (r_ff.state == psram_host_pkg::S_SLEEP);
  assign densityValid    = r_ff.densityValid;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  int   lowCycles;
  logic inHold;
  logic inLow;
  logic [13:0] holdCnt_ff;
  logic [13:0] lowCnt_ff;
  assign lowCycles = `PWR_LOW_CYC;
  assign inHold = (r_ff.state == psram_host_pkg::S_PWR_HOLD);
  assign inLow  = (r_ff.state == psram_host_pkg::S_PWR_LOW);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      holdCnt_ff <= 14'h0;
      lowCnt_ff  <= 14'h0;
    end else begin
      holdCnt_ff <= inHold ? holdCnt_ff + 14'h1 : (inLow ? 14'h0 : holdCnt_ff);
      lowCnt_ff  <= inLow ? lowCnt_ff + 14'h1 : (inHold ? lowCnt_ff : 14'h0);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  low_phase_a: assert property (inLow |-> !standbyCtl && csN)
    else $error("standby pin or select wrong during power-up low phase");
  low_len_a: assert property ($rose(standbyCtl) && !$past(sleeping) |->
                              lowCnt_ff >= 14'(lowCycles))
    else $error("standby pin released too early");
  sel_first_a: assert property ($rose(standbyCtl) |-> csN && $past(csN))
    else $error("select not high when standby pin rose");
  hold_len_a: assert property ($past(inHold) && !inHold |->
                               holdCnt_ff == holdCycles && csN && standbyCtl)
    else $error("release hold before first select has wrong length");
  sleep_pins_a: assert property (!standbyCtl |-> csN && !dqOe)
    else $error("pins active while standby pin low");
  sleep_gate_a: assert property ($fell(standbyCtl) |-> densityValid)
    else $error("partial standby entered before density programmed");
  rw_excl_a: assert property (!weN |-> oeN && dqOe && !csN)
    else $error("write strobe without drive or with output enable");
  page_stable_a: assert property (r_ff.isPage && $rose(r_ff.state == psram_host_pkg::S_ACCESS)
                                  |-> $stable(addrPin[20:3]) && !$past(csN))
    else $error("upper address moved inside a page");
  prog_addr_a: assert property (r_ff.progActive && !csN |-> addrPin == `TOP_ADDR)
    else $error("mode entry cycle not at top address");
  prog_toggle_a: assert property (r_ff.progActive && $fell(csN) |=>
                                  !csN [*1] ##[1:20] csN)
    else $error("select not toggled between entry cycles");
  wake_none_a: assert property (sleeping && wakeReq && r_ff.density == `DENSITY_NONE
                                |=> inLow && !standbyCtl)
    else $error("wake from density none skipped power-up sequence");

endmodule

/* test/psram_dev_model.sv */
// behavioural pseudo-static ram as seen on the host controller pins
// assumes the pins are registered on clk and read data is wanted in the same cycle
`timescale 1ns/1ps
module psram_dev_model (
  input  wire logic        clk,
  input  wire logic [20:0] addrPin,
  input  wire logic [15:0] dqOut,
  input  wire logic        csN,
  input  wire logic        oeN,
  input  wire logic        weN,
  input  wire logic        low_byte_sel_n,
  input  wire logic        high_byte_sel_n,
  input  wire logic        standbyCtl,
  output logic      [15:0] dqIn,
  output logic      [1:0]  modeDensity,
  output logic             modeSet
);
  logic [15:0] mem [int];
  int          gone [$];
  int          lim;
  logic [15:0] lastDq = 16'h0000;
  logic [15:0] word;
  logic        rd;
  logic [20:0] cycAddr = 21'h000000;
  logic [15:0] cycData = 16'h0000;
  logic        cycWr = 1'b0;
  logic        prevCs = 1'b1;
  logic        prevStb = 1'b0;
  logic [1:0]  entry = 2'h0;

  initial modeSet = 1'b0;
  initial modeDensity = 2'h0;

  // ------------------------------------------------------------------
  // read decode
  // ------------------------------------------------------------------
  // an undriven lane shows the inverse of its last value, never a kind copy
  always @* begin
    rd = standbyCtl && !csN && !oeN && weN;
    word = mem.exists(int'(addrPin)) ? mem[int'(addrPin)] : 16'h5a5a;
    dqIn[7:0] = (rd && !low_byte_sel_n) ? word[7:0] : ~lastDq[7:0];
    dqIn[15:8] = (rd && !high_byte_sel_n) ? word[15:8] : ~lastDq[15:8];
  end

  // ------------------------------------------------------------------
  // writes, mode entry and partial refresh
  // ------------------------------------------------------------------
  // each read stands alone, so a page may start and end anywhere
  always @(posedge clk) begin
    lastDq <= dqIn;
    prevCs <= csN;
    prevStb <= standbyCtl;
    if (standbyCtl && !csN) begin
      cycAddr <= addrPin;
      cycWr <= prevCs ? !weN : (cycWr | !weN);
      if (!weN) begin
        cycData <= dqOut;
        if (!low_byte_sel_n) mem[int'(addrPin)][7:0] = dqOut[7:0];
        if (!high_byte_sel_n) mem[int'(addrPin)][15:8] = dqOut[15:8];
      end
    end
    // a cycle counts for mode entry only when select toggles high
    if (standbyCtl && csN && !prevCs) begin
      if (cycAddr != 21'h1fffff) entry <= 2'h0;
      else if (!cycWr) entry <= (entry < 2'h2) ? entry + 2'h1 : 2'h0;
      else if (entry == 2'h2 && cycData == 16'h0000) entry <= 2'h3;
      else begin
        if (entry == 2'h3 && cycData[15:2] == 14'h0001) begin
          modeDensity <= cycData[1:0];
          modeSet <= 1'b1;
        end
        entry <= 2'h0;
      end
    end
    if (!standbyCtl && prevStb) begin
      lim = !modeSet ? 0 : (modeDensity == 2'h3) ? 0 : (32'h100000 >> modeDensity);
      gone.delete();
      foreach (mem[k]) if (k >= lim) gone.push_back(k);
      foreach (gone[i]) mem.delete(gone[i]);
    end
  end
endmodule

/* test/psram_host_tb.sv */
// self-checking bench for the pseudo-static ram host controller
// assumes the device model stands on the pins; hold time shortened by parameter
`timescale 1ns/1ps
`include "psram_host_regs.svh"
module psram_host_tb;
  localparam logic [13:0] HOLD = 14'h0014;
  logic clk = 1'b0, rst_n = 1'b0, reqValid = 1'b0, reqWrite = 1'b0;
  logic [20:0] reqAddr = 21'h000000;
  logic [15:0] reqData = 16'h0000;
  logic [1:0] reqByteEn = 2'h0, densityCode = 2'h0, modeDensity;
  logic densityReq = 1'b0, sleepReq = 1'b0, wakeReq = 1'b0;
  logic reqReady, rspValid, cmdReady, initDone, sleeping, densityValid, dqOe, modeSet;
  logic csN, oeN, weN, low_byte_sel_n, high_byte_sel_n, standbyCtl;
  logic [20:0] addrPin;
  logic [15:0] rspData, dqOut, dqIn;
  int errors = 0, checks = 0, cyc = 0;
  logic [15:0] expData [$], expMask [$];
  int expLat [$], takeCyc [$];

  always #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  psram_host #(.holdCycles(HOLD)) i_dut (.clk, .rst_n, .reqValid, .reqReady, .reqWrite,
    .reqAddr, .reqData, .reqByteEn, .rspValid, .rspData, .densityReq, .densityCode,
    .sleepReq, .wakeReq, .cmdReady, .initDone, .sleeping, .densityValid, .addrPin, .dqOut,
    .dqOe, .dqIn, .csN, .oeN, .weN, .low_byte_sel_n, .high_byte_sel_n, .standbyCtl);
  psram_dev_model i_dev (.clk, .addrPin, .dqOut, .csN, .oeN, .weN, .low_byte_sel_n,
    .high_byte_sel_n, .standbyCtl, .dqIn, .modeDensity, .modeSet);

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic expect_eq(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic summarize();
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // read answers are matched in order; latency counts from the taking edge
  always @(negedge clk) if (rspValid === 1'b1) begin
    if (expData.size() == 0) expect_eq("unasked rspValid", 0, 1);
    else begin
      expect_eq("rspData", expData.pop_front(), rspData & expMask.pop_front());
      expect_eq("read latency", expLat.pop_front(), cyc - takeCyc.pop_front());
    end
  end

  // request stays up until taken; the next call may keep it up for a page
  task automatic issue(input logic wr, input logic [20:0] a, input logic [15:0] d,
                       input logic [1:0] be, input int lat);
    int n;
    n = 0;
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqAddr <= a;
    reqData <= d;
    reqByteEn <= be;
    do begin @(negedge clk); n++; end while (reqReady !== 1'b1 && n < 30000);
    if (!wr) begin
      expMask.push_back({{8{be[1]}}, {8{be[0]}}});
      expData.push_back(d & {{8{be[1]}}, {8{be[0]}}});
      expLat.push_back(lat);
      takeCyc.push_back(cyc + 1);
    end
    @(posedge clk);
  endtask

  task automatic drain();
    reqValid <= 1'b0;
    repeat (10) @(posedge clk);
    expect_eq("pending reads", 0, expData.size());
  endtask

  task automatic command(input logic [2:0] sel, input logic [1:0] code);
    int n;
    n = 0;
    {wakeReq, sleepReq, densityReq} <= sel;
    densityCode <= code;
    do begin @(negedge clk); n++; end while (cmdReady !== 1'b1 && n < 100);
    @(posedge clk);
    {wakeReq, sleepReq, densityReq} <= 3'b000;
    repeat (2) @(posedge clk);
  endtask

  task automatic program_density(input logic [1:0] code);
    command(3'b001, code);
    repeat (40) @(posedge clk);
    expect_eq("densityValid", 1, densityValid);
    expect_eq("mode register", {1'b1, code}, {modeSet, modeDensity});
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic powerup();
    int low;
    int hold;
    int bad;
    low = 0;
    hold = 0;
    bad = 0;
    while (standbyCtl !== 1'b1 && low < 10000) begin @(negedge clk); low++; end
    expect_eq("standby low span", 1, low >= `PWR_LOW_CYC);
    expect_eq("select at standby rise", 1, csN);
    while (initDone !== 1'b1 && hold < 10000) begin
      if (csN !== 1'b1 || standbyCtl !== 1'b1) bad++;
      @(negedge clk);
      hold++;
    end
    expect_eq("hold span", 1, hold >= HOLD);
    expect_eq("hold disturbed", 0, bad);
    @(posedge clk);
  endtask

  task automatic byte_lanes();
    issue(1'b1, 21'h000123, 16'h1234, 2'b11, 0);
    issue(1'b1, 21'h000123, 16'ha5c3, 2'b01, 0);
    issue(1'b1, 21'h1ffff0, 16'hbeef, 2'b10, 0);
    issue(1'b0, 21'h000123, 16'h12c3, 2'b11, 4);
    issue(1'b0, 21'h1ffff0, 16'hbe00, 2'b10, 4);
    issue(1'b0, 21'h000123, 16'h00c3, 2'b01, 4);
    drain();
  endtask

  // fixed scattered start and order inside one page, then both ways of ending it
  task automatic page_reads();
    int offs [5] = '{5, 2, 7, 0, 3};
    for (int i = 0; i < 9; i++) issue(1'b1, 21'h002a08 + 21'(i), 16'h7700 + 16'(i), 2'b11, 0);
    foreach (offs[i])
      issue(1'b0, 21'h002a08 + 21'(offs[i]), 16'h7700 + 16'(offs[i]), 2'b11, i ? 2 : 4);
    issue(1'b0, 21'h002a10, 16'h7708, 2'b11, 4);
    drain();
    issue(1'b0, 21'h002a0e, 16'h7706, 2'b11, 4);
    drain();
  endtask

  // low block kept over partial standby for each retaining density
  task automatic retention(input logic [1:0] code);
    logic [20:0] top;
    top = 21'h100000 >> code;
    program_density(code);
    issue(1'b1, top - 21'h000008, 16'h4c40 + 16'(code), 2'b11, 0);
    drain();
    command(3'b010, 2'h0);
    expect_eq("standby in sleep", 0, standbyCtl);
    expect_eq("sleeping", 1, sleeping);
    repeat (20) @(posedge clk);
    expect_eq("select in sleep", 1, csN);
    command(3'b100, 2'h0);
    expect_eq("standby after wake", 1, standbyCtl);
    expect_eq("ready after wake", 1, initDone);
    issue(1'b0, top - 21'h000008, 16'h4c40 + 16'(code), 2'b11, 4);
    drain();
  endtask

  task automatic no_retention();
    program_density(2'h3);
    command(3'b010, 2'h0);
    command(3'b100, 2'h0);
    expect_eq("init after wake", 0, initDone);
    powerup();
    issue(1'b1, 21'h000040, 16'h3c3c, 2'b11, 0);
    issue(1'b0, 21'h000040, 16'h3c3c, 2'b11, 4);
    drain();
  endtask

  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    expect_eq("standby in reset", 0, standbyCtl);
    expect_eq("select in reset", 1, csN);
    @(posedge clk);
    rst_n <= 1'b1;
    powerup();
    command(3'b010, 2'h0);
    repeat (5) @(posedge clk);
    expect_eq("sleep refused", 1, standbyCtl);
    byte_lanes();
    page_reads();
    for (int c = 0; c < 3; c++) retention(2'(c));
    no_retention();
    summarize();
  end

  // the run needs about 4600 cycles; this limit leaves wide margin
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    summarize();
  end
endmodule
